/* File: hdl/twm_core.sv */
`timescale 1ns/1ns
`default_nettype none

module twm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule : twm_fifo

module twm_core
    import twm_pkg::*;
(
    // core clock, reset, enable
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ref_ce,
    // link clock
    input wire logic link_clk,
    // mode commands (one-cycle pulses) and addresses
    input wire logic master_on_cmd,
    input wire logic master_off_cmd,
    input wire logic slave_on_cmd,
    input wire logic slave_off_cmd,
    input wire logic [ADDR_W-1:0] own_slave_address,
    input wire logic [ADDR_W-1:0] target_device_address,
    // holding registers
    input wire logic thr_wr,
    input wire logic [BYTE_W-1:0] transmit_holding_register,
    input wire logic rhr_rd,
    output logic [BYTE_W-1:0] receive_holding_register,
    // status
    input wire logic status_rd,
    output logic [ST_W-1:0] status_bits,
    output logic slave_access_flag,
    output logic nack_flag,
    output logic arb_lost_flag,
    // two-wire port pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    function automatic logic filt(input logic cur, input logic s2, input logic s3);
        filt = (s2 == s3) ? s2 : cur;
    endfunction : filt

    // ---------------- core domain ----------------
    logic master_en_r;
    logic [BYTE_W-1:0] thr_data_r;
    logic tx_req_tgl_r;
    logic rx_ack_tgl_r;
    logic rx_pend_r;
    logic [EV_W-1:0] ev_s1_r, ev_s2_r, ev_s3_r;
    logic [1:0] acc_s_r, rd_s_r;
    logic [EV_W-1:0] ev_in;
    logic fifo_in_ready, fifo_out_valid;
    logic [BYTE_W-1:0] fifo_out_data;

    // ---------------- link domain ----------------
    logic [1:0] lrst_s_r, lce_s_r, mst_en_s_r, slv_en_s_r;
    logic [ADDR_W-1:0] own_s1_r, own_s2_r, tgt_s1_r, tgt_s2_r;
    logic [2:0] tx_tgl_s_r, rx_ack_s_r, scl_s_r, sda_s_r;
    logic scl_f, sda_f, scl_p, sda_p;
    logic lrst_n, lce, tx_edge, rx_ack_edge;
    logic start_det, stop_det, scl_rise, scl_fall;
    logic [8:0] m_cnt_r;
    logic m_tick, m_go;
    twm_mst_e m_st;
    twm_slv_e s_st;
    logic [1:0] m_q;
    logic [2:0] m_bit;
    logic [BYTE_W-1:0] m_sh, s_sh, tx_byte, rx_data;
    logic m_scl_low, m_sda_low, m_nack;
    logic s_scl_low, s_sda_low, s_nack, s_acc, s_rd, s_wait_rx, s_wait_tx;
    logic [3:0] s_bit;
    logic tx_have, rx_busy, bus_busy, lost_blk, slv_on;
    logic [EV_W-1:0] ev_p, ev_tgl;
    logic scl_oe_r, sda_oe_r;

    assign ev_in = ev_s2_r ^ ev_s3_r;

    // mode bits change only on software commands, never on arbitration loss
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            master_en_r <= 1'b0;
            slv_on <= 1'b0;
        end else if (ref_ce) begin
            if (master_on_cmd) master_en_r <= 1'b1;
            else if (master_off_cmd) master_en_r <= 1'b0;
            if (slave_on_cmd) slv_on <= 1'b1;
            else if (slave_off_cmd) slv_on <= 1'b0;
        end
    end

    // holding register write; each write replaces the data, whether or not the link has taken it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            thr_data_r <= '0;
            tx_req_tgl_r <= 1'b0;
        end else if (ref_ce && thr_wr) begin
            thr_data_r <= transmit_holding_register;
            tx_req_tgl_r <= ~tx_req_tgl_r;
        end
    end

    // event and level crossings from the link domain
    always_ff @(posedge ref_clk) begin
        ev_s1_r <= ev_tgl;
        ev_s2_r <= ev_s1_r;
        acc_s_r <= {acc_s_r[0], s_acc};
        rd_s_r <= {rd_s_r[0], s_rd};
        if (!rstn) begin
            ev_s3_r <= '0;
        end else if (ref_ce) begin
            ev_s3_r <= ev_s2_r;
        end
    end

    // received bytes wait here until the buffer accepts them
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_pend_r <= 1'b0;
            rx_ack_tgl_r <= 1'b0;
        end else if (ref_ce) begin
            if (rx_pend_r && fifo_in_ready) begin
                rx_pend_r <= 1'b0;
                rx_ack_tgl_r <= ~rx_ack_tgl_r;
            end
            if (ev_in[EV_RX]) rx_pend_r <= 1'b1;
        end
    end

    twm_fifo #(.WIDTH(BYTE_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
        .clk(ref_clk),
        .rst_n(rstn),
        .ce(ref_ce),
        .in_valid(rx_pend_r),
        .in_ready(fifo_in_ready),
        .in_data(rx_data),
        .out_valid(fifo_out_valid),
        .out_ready(rhr_rd),
        .out_data(fifo_out_data)
    );

    // status flags; a set in the same cycle as a clear always wins
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status_bits <= {RST_FLAG, RST_TX_HOLDING_READY, RST_FLAG, RST_TRANSFER_COMPLETE_FLAG};
            slave_access_flag <= RST_FLAG;
            nack_flag <= RST_FLAG;
            arb_lost_flag <= RST_FLAG;
            receive_holding_register <= '0;
        end else if (ref_ce) begin
            if (thr_wr) status_bits[ST_TX_HOLDING_READY] <= 1'b0;
            if (ev_in[EV_TXMV] || ev_in[EV_NACK]) status_bits[ST_TX_HOLDING_READY] <= 1'b1;
            if (master_on_cmd) status_bits[ST_TX_HOLDING_READY] <= 1'b1;
            if (thr_wr) status_bits[ST_TRANSFER_COMPLETE_FLAG] <= 1'b0;
            if (ev_in[EV_CMP]) status_bits[ST_TRANSFER_COMPLETE_FLAG] <= 1'b1;
            status_bits[ST_RX_HOLDING_READY] <= fifo_out_valid && !(rhr_rd && fifo_out_valid);
            // only a real buffer head is shown, so an empty buffer never exposes stale memory
            if (fifo_out_valid) receive_holding_register <= fifo_out_data;
            status_bits[ST_SLAVE_READ_DIR] <= rd_s_r[1] && acc_s_r[1];
            slave_access_flag <= acc_s_r[1];
            if (status_rd) nack_flag <= 1'b0;
            if (ev_in[EV_NACK]) nack_flag <= 1'b1;
            if (status_rd) arb_lost_flag <= 1'b0;
            if (ev_in[EV_ARB]) arb_lost_flag <= 1'b1;
        end
    end

    // ---------------- link domain logic ----------------
    assign lrst_n = lrst_s_r[1];
    assign lce = lce_s_r[1];
    assign tx_edge = tx_tgl_s_r[1] ^ tx_tgl_s_r[2];
    assign rx_ack_edge = rx_ack_s_r[1] ^ rx_ack_s_r[2];
    assign start_det = scl_f && scl_p && sda_p && !sda_f;
    assign stop_det = scl_f && scl_p && !sda_p && sda_f;
    assign scl_rise = scl_f && !scl_p;
    assign scl_fall = !scl_f && scl_p;
    assign m_tick = (m_cnt_r == QUARTER_LAST);
    // a released clock held low by another party stretches the low phase
    assign m_go = m_tick && (m_q != 2'h2 || scl_f);

    // plain synchronisers; reset, enable and config are slow levels
    always_ff @(posedge link_clk) begin
        lrst_s_r <= {lrst_s_r[0], rstn};
        lce_s_r <= {lce_s_r[0], ref_ce};
        mst_en_s_r <= {mst_en_s_r[0], master_en_r};
        slv_en_s_r <= {slv_en_s_r[0], slv_on};
        own_s1_r <= own_slave_address;
        own_s2_r <= own_s1_r;
        tgt_s1_r <= target_device_address;
        tgt_s2_r <= tgt_s1_r;
        tx_tgl_s_r <= {tx_tgl_s_r[1:0], tx_req_tgl_r};
        rx_ack_s_r <= {rx_ack_s_r[1:0], rx_ack_tgl_r};
        scl_s_r <= {scl_s_r[1:0], scl_i};
        sda_s_r <= {sda_s_r[1:0], sda_i};
    end

    // pin levels count once the second and third stages agree
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            scl_f <= RST_PIN_LEVEL;
            sda_f <= RST_PIN_LEVEL;
            scl_p <= RST_PIN_LEVEL;
            sda_p <= RST_PIN_LEVEL;
        end else if (lce) begin
            scl_f <= filt(scl_f, scl_s_r[1], scl_s_r[2]);
            sda_f <= filt(sda_f, sda_s_r[1], sda_s_r[2]);
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // quarter-period timer for the generated clock
    always_ff @(posedge link_clk) begin
        if (!lrst_n || m_st inside {M_IDLE, M_WAIT_FREE, M_LOST}) begin
            m_cnt_r <= '0;
        end else if (lce) begin
            m_cnt_r <= m_tick ? '0 : m_cnt_r + 9'h1;
        end
    end

    // protocol engine: master and slave share the holding bytes
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            m_st <= M_IDLE;
            s_st <= S_IDLE;
            m_q <= '0;
            m_bit <= '0;
            m_sh <= '0;
            s_sh <= '0;
            s_bit <= '0;
            tx_byte <= '0;
            rx_data <= '0;
            {m_scl_low, m_sda_low, m_nack, s_scl_low, s_sda_low, s_nack} <= '0;
            {s_acc, s_rd, s_wait_rx, s_wait_tx} <= '0;
            {tx_have, rx_busy, bus_busy, lost_blk} <= '0;
            ev_p <= '0;
        end else if (lce) begin
            ev_p <= '0;
            if (tx_edge) begin
                tx_have <= 1'b1;
                tx_byte <= thr_data_r;
            end
            if (rx_ack_edge) rx_busy <= 1'b0;
            if (start_det) bus_busy <= 1'b1;
            if (stop_det) begin
                bus_busy <= 1'b0;
                lost_blk <= 1'b0;
            end
            unique case (m_st)
                M_IDLE: if (mst_en_s_r[1] && tx_have) m_st <= M_WAIT_FREE;
                M_WAIT_FREE: begin
                    if (!mst_en_s_r[1]) begin
                        m_st <= M_IDLE;
                    end else if (!bus_busy) begin
                        m_q <= '0;
                        m_st <= M_START;
                    end
                end
                M_START: if (m_tick) begin
                    if (m_q == 2'h0) begin
                        m_sda_low <= 1'b1;
                        m_q <= 2'h1;
                    end else begin
                        m_scl_low <= 1'b1;
                        m_sh <= {tgt_s2_r, 1'b0};
                        m_bit <= '0;
                        m_q <= '0;
                        m_st <= M_BIT;
                    end
                end
                M_BIT: if (m_go) begin
                    m_q <= m_q + 2'h1;
                    unique case (m_q)
                        2'h0: m_sda_low <= ~m_sh[7];
                        2'h1: m_scl_low <= 1'b0;
                        2'h2: if (!m_sda_low && !sda_f) begin
                            m_scl_low <= 1'b0;
                            m_sda_low <= 1'b0;
                            tx_have <= 1'b0;
                            lost_blk <= 1'b1;
                            ev_p[EV_ARB] <= 1'b1;
                            m_st <= M_LOST;
                        end
                        2'h3: begin
                            m_scl_low <= 1'b1;
                            m_sh <= {m_sh[6:0], 1'b0};
                            m_bit <= m_bit + 3'h1;
                            if (m_bit == M_BIT_LAST) m_st <= M_ACK;
                        end
                    endcase
                end
                M_ACK: if (m_go) begin
                    m_q <= m_q + 2'h1;
                    unique case (m_q)
                        2'h0: m_sda_low <= 1'b0;
                        2'h1: m_scl_low <= 1'b0;
                        2'h2: m_nack <= sda_f;
                        2'h3: begin
                            m_scl_low <= 1'b1;
                            m_bit <= '0;
                            if (m_nack) begin
                                ev_p[EV_NACK] <= 1'b1;
                                m_st <= M_STOP;
                            end else if (tx_have) begin
                                m_sh <= tx_byte;
                                tx_have <= 1'b0;
                                ev_p[EV_TXMV] <= 1'b1;
                                m_st <= M_BIT;
                            end else begin
                                m_st <= M_STOP;
                            end
                        end
                    endcase
                end
                M_STOP: if (m_tick) begin
                    m_q <= m_q + 2'h1;
                    unique case (m_q)
                        2'h0: m_sda_low <= 1'b1;
                        2'h1: m_scl_low <= 1'b0;
                        2'h2: m_sda_low <= 1'b0;
                        2'h3: begin
                            ev_p[EV_CMP] <= 1'b1;
                            m_st <= M_IDLE;
                        end
                    endcase
                end
                M_LOST: if (stop_det) begin
                    ev_p[EV_CMP] <= 1'b1;
                    m_st <= M_IDLE;
                end
            endcase

            if (stop_det) begin
                if (s_acc) ev_p[EV_CMP] <= 1'b1;
                {s_acc, s_sda_low, s_scl_low, s_wait_rx, s_wait_tx} <= '0;
                s_st <= S_IDLE;
            end else if (start_det) begin
                s_bit <= '0;
                s_sda_low <= 1'b0;
                // after a lost arbitration this transaction is never answered
                s_st <= (slv_en_s_r[1] && !lost_blk && m_st == M_IDLE) ? S_ADDR : S_IGNORE;
            end else if (s_st inside {S_ADDR, S_WDATA, S_RDATA}) begin
                // clock held low while the core has not taken the last byte
                if (s_wait_rx && !rx_busy) begin
                    rx_busy <= 1'b1;
                    rx_data <= s_sh;
                    ev_p[EV_RX] <= 1'b1;
                    s_sda_low <= 1'b1;
                    s_scl_low <= 1'b0;
                    s_wait_rx <= 1'b0;
                end
                if (s_wait_tx && tx_have) begin
                    s_sh <= tx_byte;
                    tx_have <= 1'b0;
                    s_sda_low <= ~tx_byte[7];
                    s_scl_low <= 1'b0;
                    s_wait_tx <= 1'b0;
                end
                if (scl_rise) begin
                    if (s_bit < S_BIT_DATA && s_st != S_RDATA) s_sh <= {s_sh[6:0], sda_f};
                    if (s_bit == S_BIT_DATA) s_nack <= sda_f;
                    s_bit <= s_bit + 4'h1;
                end
                if (scl_fall) begin
                    if (s_bit == S_BIT_DATA) begin
                        if (s_st == S_ADDR) begin
                            if (s_sh[7:1] == own_s2_r) begin
                                s_sda_low <= 1'b1;
                                s_acc <= 1'b1;
                                s_rd <= s_sh[0];
                            end else begin
                                s_st <= S_IGNORE;
                            end
                        end else if (s_st == S_WDATA) begin
                            s_scl_low <= 1'b1;
                            s_wait_rx <= 1'b1;
                        end else begin
                            s_sda_low <= 1'b0;
                        end
                    end else if (s_bit == S_BIT_ACK) begin
                        s_bit <= '0;
                        s_sda_low <= 1'b0;
                        if (s_st == S_RDATA && s_nack) begin
                            ev_p[EV_NACK] <= 1'b1;
                            ev_p[EV_TXMV] <= 1'b1;
                            s_st <= S_IGNORE;
                        end else if (s_st == S_WDATA || !s_rd) begin
                            s_st <= S_WDATA;
                        end else begin
                            if (s_st == S_RDATA) ev_p[EV_TXMV] <= 1'b1;
                            s_st <= S_RDATA;
                            s_scl_low <= 1'b1;
                            s_wait_tx <= 1'b1;
                        end
                    end else if (s_st == S_RDATA) begin
                        s_sh <= {s_sh[6:0], 1'b0};
                        s_sda_low <= ~s_sh[6];
                    end
                end
            end
        end
    end

    // events leave as toggles so the core sees each one exactly once
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            ev_tgl <= '0;
        end else if (lce) begin
            ev_tgl <= ev_tgl ^ ev_p;
        end
    end

    // open-drain pins: only ever pulled low
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (lce) begin
            scl_oe_r <= m_scl_low | s_scl_low;
            sda_oe_r <= m_sda_low | s_sda_low;
        end
    end

    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
endmodule : twm_core
`default_nettype wire

/* File: hdl/twm_pkg.sv */
`default_nettype none
package twm_pkg;
    // data and address widths, receive buffer depth
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int RX_FIFO_DEPTH = 4;

    // status word bit positions
    localparam int ST_TRANSFER_COMPLETE_FLAG = 0;
    localparam int ST_RX_HOLDING_READY = 1;
    localparam int ST_TX_HOLDING_READY = 2;
    localparam int ST_SLAVE_READ_DIR = 3;
    localparam int ST_W = 4;

    // link-to-core event indices, each carried as a toggle
    localparam int EV_TXMV = 0;
    localparam int EV_NACK = 1;
    localparam int EV_RX = 2;
    localparam int EV_ARB = 3;
    localparam int EV_CMP = 4;
    localparam int EV_W = 5;

    // values after reset
    localparam logic RST_TRANSFER_COMPLETE_FLAG = 1'b1;
    localparam logic RST_TX_HOLDING_READY = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_PIN_LEVEL = 1'b1;

    // serial clock timing, counted in link clock cycles
    localparam int SCL_PERIOD_NS = 10000;
    localparam int LINK_CLK_PERIOD_PS = 6000;
    localparam int QUARTER_CYC = (SCL_PERIOD_NS * 1000 / 4) / LINK_CLK_PERIOD_PS;
    localparam logic [8:0] QUARTER_LAST = 9'(QUARTER_CYC - 1);

    // bit counters
    localparam logic [2:0] M_BIT_LAST = 3'h7;
    localparam logic [3:0] S_BIT_DATA = 4'h8;
    localparam logic [3:0] S_BIT_ACK = 4'h9;

    typedef enum logic [2:0] {
        M_IDLE, M_WAIT_FREE, M_START, M_BIT, M_ACK, M_STOP, M_LOST
    } twm_mst_e;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_WDATA, S_RDATA, S_IGNORE
    } twm_slv_e;
endpackage : twm_pkg
`default_nettype wire

/* File: verif/twm_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module twm_checker
    import twm_pkg::*;
(
    // clock and requests
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ref_ce,
    input wire logic master_on_cmd,
    input wire logic thr_wr,
    input wire logic rhr_rd,
    input wire logic status_rd,
    // observed outputs
    input wire logic [BYTE_W-1:0] receive_holding_register,
    input wire logic [ST_W-1:0] status_bits,
    input wire logic slave_access_flag,
    input wire logic nack_flag,
    input wire logic arb_lost_flag,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_write_clears: assert property (thr_wr && ref_ce |=>
        !status_bits[ST_TX_HOLDING_READY] && !status_bits[ST_TRANSFER_COMPLETE_FLAG]) else $error("write left tx flags");
    a_enable_ready: assert property (master_on_cmd && ref_ce |=> status_bits[ST_TX_HOLDING_READY])
        else $error("tx ready not set on enable");
    a_empty_read: assert property (rhr_rd && ref_ce && !status_bits[ST_RX_HOLDING_READY]
        |=> $stable(receive_holding_register)) else $error("empty read changed data");
    a_arb_held: assert property (arb_lost_flag && !status_rd |=> arb_lost_flag)
        else $error("lost flag dropped unread");
    a_nack_held: assert property (nack_flag && !status_rd |=> nack_flag)
        else $error("nack flag dropped unread");
    a_nack_ready: assert property ($rose(nack_flag) |-> ##[0:1] status_bits[ST_TX_HOLDING_READY])
        else $error("tx ready not set with nack");
    // slave stretching is excluded, it may hold the clock with complete still set
    a_frame_busy: assert property (scl_oe && !slave_access_flag |->
        !status_bits[ST_TRANSFER_COMPLETE_FLAG]) else $error("complete high in frame");
    a_lost_quiet: assert property (arb_lost_flag && !status_bits[ST_TRANSFER_COMPLETE_FLAG] |->
        !sda_oe && !scl_oe) else $error("lines driven after loss");
endmodule : twm_checker
bind twm_core twm_checker chk_i (.ref_clk(ref_clk), .rstn(rstn), .ref_ce(ref_ce),
    .master_on_cmd(master_on_cmd), .thr_wr(thr_wr), .rhr_rd(rhr_rd), .status_rd(status_rd),
    .receive_holding_register(receive_holding_register), .status_bits(status_bits),
    .slave_access_flag(slave_access_flag), .nack_flag(nack_flag),
    .arb_lost_flag(arb_lost_flag), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

/* File: verif/twm_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module twm_peer #(
    parameter logic [6:0] ADDR = 7'h55
) (
    // shared lines
    input wire logic scl,
    input wire logic sda,
    // behaviour controls
    input wire logic jam,
    input wire logic nak,
    // line pulls and last byte taken
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] got = 8'h00
);
    logic m_scl = 0, m_sda = 0, s_sda = 0, j_sda = 0, sel = 0;
    logic [7:0] sh = 8'h00;
    int n = 0, nb = 0;
    assign scl_oe = m_scl;
    assign sda_oe = m_sda | s_sda | j_sda;
    always @(negedge sda) if (scl) begin
        n = 0;
        nb = 0;
        sel = 0;
    end
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        n++;
    end
    // jam plays a rival master sending zeros; dropping it with scl high is its stop
    always @(negedge scl) begin
        s_sda = 0;
        if (jam) j_sda = 1;
        if (n == 8 && nb == 0) sel = (sh[7:1] == ADDR) && !sh[0];
        if (n == 8) s_sda = sel && (nb == 0 || !nak);
        if (n == 8 && nb > 0 && sel) got = sh;
        if (n == 9) begin
            n = 0;
            nb++;
        end
    end
    always @(negedge jam) j_sda = 0;
    task automatic mbit(input logic b, output logic r);
        m_sda = !b;
        #2500 m_scl = 0;
        wait (scl === 1'b1);
        #5000 r = sda;
        m_scl = 1;
        #2500;
    endtask : mbit
    task automatic mstart;
        m_sda = 1;
        #5000 m_scl = 1;
        #2500;
    endtask : mstart
    task automatic mstop;
        m_sda = 1;
        #2500 m_scl = 0;
        wait (scl === 1'b1);
        #5000 m_sda = 0;
        #5000;
    endtask : mstop
    task automatic mbyte(input logic [7:0] b, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) mbit(b[i], r[i]);
        mbit(1'b1, ack);
    endtask : mbyte
endmodule : twm_peer
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import twm_pkg::*;
    logic ref_clk = 0, link_clk = 1, rstn = 0, jam = 0, nak = 0, a;
    logic [6:0] p = 0;
    logic [7:0] thr_d = 0, d, rhr, got;
    logic [ST_W-1:0] st;
    logic sacc, nck, arb, scl_oe, sda_oe, scl_o, sda_o, pscl, psda;
    wire logic scl = ~(scl_oe | pscl);
    wire logic sda = ~(sda_oe | psda);
    wire logic [6:0] obs = {arb, nck, sacc, st};
    int fail_count = 0, cmp_count = 0;
    always #25 ref_clk = ~ref_clk;
    always #3 link_clk = ~link_clk;
    twm_core uut (.ref_clk(ref_clk), .rstn(rstn), .ref_ce(1'b1), .link_clk(link_clk),
        .master_on_cmd(p[6]), .master_off_cmd(p[5]), .slave_on_cmd(p[4]), .slave_off_cmd(p[3]),
        .own_slave_address(7'h33), .target_device_address(7'h55), .thr_wr(p[2]),
        .transmit_holding_register(thr_d), .rhr_rd(p[1]), .receive_holding_register(rhr),
        .status_rd(p[0]), .status_bits(st), .slave_access_flag(sacc), .nack_flag(nck),
        .arb_lost_flag(arb), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe));
    twm_peer peer (.scl(scl), .sda(sda), .jam(jam), .nak(nak), .scl_oe(pscl), .sda_oe(psda),
        .got(got));
    task automatic go(input logic [6:0] v, input logic [7:0] b);
        @(posedge ref_clk);
        #1 p = v;
        thr_d = b;
        @(posedge ref_clk);
        #1 p = 0;
    endtask : go
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // bounded wait on one observed bit, a frame is far below the limit
    task automatic wst(input int i, input logic v);
        for (int k = 0; k < 20000 && obs[i] !== v; k++) @(posedge ref_clk);
        chk(obs[i], v);
    endtask : wst
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        #4000000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1;
        chk({scl_o, sda_o, obs}, 9'h001);
        go(7'h02, 0);
        go(7'h40, 0);
        chk(st[ST_TX_HOLDING_READY], 1);
        go(7'h04, 8'ha5);
        chk({st[ST_TX_HOLDING_READY], st[ST_TRANSFER_COMPLETE_FLAG]}, 0);
        wst(ST_TX_HOLDING_READY, 1);
        go(7'h04, 8'h3c);
        wst(ST_TRANSFER_COMPLETE_FLAG, 1);
        chk({nck, got}, 9'h03c);
        nak = 1;
        go(7'h04, 8'h0f);
        wst(ST_W + 1, 1);
        chk(st[ST_TX_HOLDING_READY], 1);
        wst(ST_TRANSFER_COMPLETE_FLAG, 1);
        go(7'h01, 0);
        chk(nck, 0);
        nak = 0;
        peer.mstart();
        go(7'h04, 8'h11);
        repeat (2000) @(posedge ref_clk);
        chk({st[ST_TRANSFER_COMPLETE_FLAG], got}, 9'h00f);
        peer.mstop();
        wst(ST_TRANSFER_COMPLETE_FLAG, 1);
        chk(got, 8'h11);
        jam = 1;
        go(7'h04, 8'h22);
        wst(ST_W + 2, 1);
        repeat (200) @(posedge ref_clk);
        chk({arb, st[ST_TRANSFER_COMPLETE_FLAG], scl_oe, sda_oe, sacc}, 5'h10);
        jam = 0;
        wst(ST_TRANSFER_COMPLETE_FLAG, 1);
        chk(arb, 1);
        go(7'h01, 0);
        chk(arb, 0);
        go(7'h04, 8'h22);
        wst(ST_TRANSFER_COMPLETE_FLAG, 1);
        chk(got, 8'h22);
        go(7'h20, 0);
        go(7'h10, 0);
        peer.mstart();
        peer.mbyte(8'h66, d, a);
        peer.mbyte(8'h5a, d, a);
        chk({a, sacc, st[ST_SLAVE_READ_DIR]}, 3'h2);
        peer.mstop();
        wst(ST_RX_HOLDING_READY, 1);
        go(7'h02, 0);
        chk({st[ST_RX_HOLDING_READY], rhr}, 9'h05a);
        peer.mstart();
        peer.mbyte(8'h67, d, a);
        fork
            peer.mbyte(8'hff, d, a);
            begin
                repeat (100) @(posedge ref_clk);
                chk(st[ST_SLAVE_READ_DIR], 1);
                go(7'h04, 8'hc3);
                chk(st[ST_TX_HOLDING_READY], 0);
            end
        join
        chk(d, 8'hc3);
        wst(ST_TX_HOLDING_READY, 1);
        chk(nck, 1);
        peer.mstop();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
